// File: command_error_capture.sv
/*
 Fault detection, capture and query unit for a command processor.
 Assumes commands arrive one per cycle as a cmd_check_t and that the
 host issues at most one query pulse per cycle.
*/
`timescale 1ns/1ps

module command_error_capture
    import fault_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Command checking
    input  wire cmd_check_t    cmdIn,
    output cmd_verdict_t       verdictOut,
    // Host query
    input  wire logic          fault_code_query,
    output query_ans_t         queryAns,
    // Status
    output logic               faultPending
);

    typedef struct packed {
        cmd_verdict_t         verdict;
        query_ans_t           ans;
        logic                 pending;
        logic                 noMemSeen;
        logic                 drain;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic [CODE_W-1:0]    detCode;
    logic                 detected;
    logic                 discard;
    logic [NUM_PAIRS-1:0] flags;
    logic [CODE_W-1:0]    bankCode;
    logic                 anyFlag;
    logic [IDX_W-1:0]     hitIdx;
    logic                 clrEn;

    // Implicit checks first, then the explicit kind from the checker
    always_comb begin
        detCode = NO_FAULT_CODE;
        if (cmdIn.valid) begin
            if (!cmdIn.enumLegal) begin
                detCode = BAD_ENUM_CODE;
            end else if (cmdIn.sizeChecked && cmdIn.sizeArg[CODE_W-1]) begin
                detCode = BAD_VALUE_CODE;
            end else begin
                case (cmdIn.explicitKind)
                    KIND_ILLEGAL_OP:    detCode = ILLEGAL_OP_CODE;
                    KIND_FB_INCOMPLETE: detCode = FB_INCOMPLETE_CODE;
                    KIND_STACK_OVER:    detCode = STACK_OVER_CODE;
                    KIND_STACK_UNDER:   detCode = STACK_UNDER_CODE;
                    KIND_TABLE_LARGE:   detCode = TABLE_LARGE_CODE;
                    KIND_NO_MEMORY:     detCode = memory_exhausted_code;
                    default:            detCode = NO_FAULT_CODE;
                endcase
            end
        end
    end

    assign detected = detCode != NO_FAULT_CODE;
    assign discard  = detected && detCode != memory_exhausted_code;
    assign anyFlag  = |flags;

    // Lowest pending pair is the one the next query answers
    always_comb begin
        hitIdx = '0;
        for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
            if (flags[i]) begin
                hitIdx = IDX_W'(i);
            end
        end
    end

    // Query consumes one pair per pulse; read data for it is already registered in the query cycle
    assign clrEn = fault_code_query && anyFlag;

    fault_pair_bank u_bank (
        .sys_clk (sys_clk),
        .rst     (rst),
        .capEn   (detected),
        .capCode (detCode),
        .clrEn   (clrEn),
        .clrIdx  (hitIdx),
        .rdIdx   (hitIdx),
        .rdCode  (bankCode),
        .flags   (flags)
    );

    always_comb begin
        state_d = state_q;
        state_d.verdict.valid     = cmdIn.valid;
        state_d.verdict.commit    = cmdIn.valid && !discard;
        state_d.verdict.ptrWrite  = cmdIn.valid && cmdIn.ptrWrite && !discard;
        state_d.verdict.result    = discard ? NO_FAULT_CODE : cmdIn.result;
        state_d.verdict.undefined = state_q.noMemSeen || (detCode == memory_exhausted_code);
        state_d.noMemSeen         = state_d.verdict.undefined;
        if (!cmdIn.hasResult) begin
            state_d.verdict.result = NO_FAULT_CODE;
        end
        state_d.ans.valid = fault_code_query;
        // Answer from the registered read-out; clear of flags happens the same edge
        state_d.ans.code  = clrEn ? bankCode : NO_FAULT_CODE;
        state_d.drain     = fault_code_query && !anyFlag;
        state_d.pending   = |flags;
        if (clrEn) begin
            state_d.pending = (flags & ~(NUM_PAIRS'(1) << hitIdx)) != '0 || detected;
        end else if (detected) begin
            state_d.pending = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign verdictOut   = state_q.verdict;
    assign queryAns     = state_q.ans;
    assign faultPending = state_q.pending;

    sequence s_fault_cmd;
        cmdIn.valid && discard;
    endsequence

    sequence s_zeroed_out;
        verdictOut.valid && !verdictOut.commit && !verdictOut.ptrWrite
            && verdictOut.result == NO_FAULT_CODE;
    endsequence

    chk_discard_no_effect: assert property (@(posedge sys_clk) disable iff (rst)
        s_fault_cmd |=> s_zeroed_out)
        else $error("faulted command not discarded");

    chk_zero_result: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && discard && cmdIn.hasResult |=> verdictOut.result == NO_FAULT_CODE)
        else $error("faulted command returned a value");

    chk_ptr_guard: assert property (@(posedge sys_clk) disable iff (rst)
        verdictOut.ptrWrite |-> $past(cmdIn.ptrWrite) && !$past(discard))
        else $error("pointer write after fault");

    chk_bad_enum_code: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !cmdIn.enumLegal |-> detCode == BAD_ENUM_CODE)
        else $error("bad enumerant not flagged");

    chk_neg_size_code: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && cmdIn.enumLegal && cmdIn.sizeChecked && cmdIn.sizeArg[CODE_W-1]
        |-> detCode == BAD_VALUE_CODE)
        else $error("negative size not flagged");

    chk_fault_captured: assert property (@(posedge sys_clk) disable iff (rst)
        detected && !anyFlag && !fault_code_query |=> flags[0] && u_bank.bank_q.code[0] == $past(detCode))
        else $error("fault not captured");

    chk_query_returns: assert property (@(posedge sys_clk) disable iff (rst)
        fault_code_query && anyFlag |=> queryAns.valid && queryAns.code != NO_FAULT_CODE
            && !flags[$past(hitIdx)])
        else $error("query did not return and clear");

    chk_zero_when_idle: assert property (@(posedge sys_clk) disable iff (rst)
        fault_code_query && !anyFlag |=> queryAns.valid && queryAns.code == NO_FAULT_CODE)
        else $error("spurious fault code returned");

    chk_reset_clean: assert property (@(posedge sys_clk)
        $fell(rst) |-> flags == '0 && !faultPending && !queryAns.valid)
        else $error("state not clean after reset");

    // Decoder checks
    // Explicit kinds only reach the decoder once both implicit checks pass
    sequence s_explicit(fault_kind_t k);
        cmdIn.valid && cmdIn.enumLegal && !(cmdIn.sizeChecked && cmdIn.sizeArg[CODE_W-1])
            && cmdIn.explicitKind == k;
    endsequence

    sequence s_query_hit;
        fault_code_query && anyFlag;
    endsequence

    chk_illegal_op_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_ILLEGAL_OP) |-> detCode == ILLEGAL_OP_CODE)
        else $error("illegal operation code wrong");

    chk_fb_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_FB_INCOMPLETE) |-> detCode == FB_INCOMPLETE_CODE)
        else $error("incomplete framebuffer code wrong");

    chk_stack_over_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_STACK_OVER) |-> detCode == STACK_OVER_CODE)
        else $error("stack overflow code wrong");

    chk_stack_under_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_STACK_UNDER) |-> detCode == STACK_UNDER_CODE)
        else $error("stack underflow code wrong");

    chk_table_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_TABLE_LARGE) |-> detCode == TABLE_LARGE_CODE)
        else $error("table size code wrong");

    chk_memory_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_NO_MEMORY) |-> detCode == memory_exhausted_code)
        else $error("memory exhaustion code wrong");

    chk_no_spurious: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_NONE) |-> !detected)
        else $error("fault raised on clean command");

    chk_idle_no_fault: assert property (@(posedge sys_clk) disable iff (rst)
        !cmdIn.valid |-> !detected)
        else $error("fault raised with no command");

    // Verdict checks
    chk_verdict_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid |=> verdictOut.valid)
        else $error("verdict missing");

    chk_verdict_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !cmdIn.valid |=> !verdictOut.valid)
        else $error("verdict without command");

    chk_commit_gated: assert property (@(posedge sys_clk) disable iff (rst)
        verdictOut.commit |-> verdictOut.valid)
        else $error("commit without verdict");

    chk_clean_commits: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !detected |=> verdictOut.commit)
        else $error("clean command not committed");

    chk_clean_result: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !detected && cmdIn.hasResult |=> verdictOut.result == $past(cmdIn.result))
        else $error("clean result altered");

    chk_no_result_zero: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !cmdIn.hasResult |=> verdictOut.result == NO_FAULT_CODE)
        else $error("result shown for command without one");

    chk_ptr_needs_commit: assert property (@(posedge sys_clk) disable iff (rst)
        verdictOut.ptrWrite |-> verdictOut.commit)
        else $error("pointer write without commit");

    chk_ptr_gated: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !cmdIn.ptrWrite |=> !verdictOut.ptrWrite)
        else $error("unrequested pointer write");

    chk_clean_ptr: assert property (@(posedge sys_clk) disable iff (rst)
        cmdIn.valid && !detected && cmdIn.ptrWrite |=> verdictOut.ptrWrite)
        else $error("clean pointer write lost");

    chk_mem_commits: assert property (@(posedge sys_clk) disable iff (rst)
        s_explicit(KIND_NO_MEMORY) |=> verdictOut.commit && verdictOut.undefined)
        else $error("memory fault not marked undefined");

    chk_undef_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        verdictOut.undefined |=> verdictOut.undefined)
        else $error("undefined mark dropped before reset");

    chk_reset_verdict: assert property (@(posedge sys_clk)
        $fell(rst) |-> !verdictOut.valid && !verdictOut.undefined)
        else $error("verdict not clean after reset");

    // Query checks
    chk_ans_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        fault_code_query |=> queryAns.valid)
        else $error("query left unanswered");

    chk_ans_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !fault_code_query |=> !queryAns.valid)
        else $error("answer without query");

    chk_flag_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        s_query_hit |=> !flags[$past(hitIdx)])
        else $error("answered pair still flagged");

    chk_answer_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_query_hit |=> queryAns.code == $past(u_bank.bank_q.code[hitIdx]))
        else $error("answer differs from pending code");

    chk_zero_answer: assert property (@(posedge sys_clk) disable iff (rst)
        queryAns.valid && queryAns.code == NO_FAULT_CODE |-> !$past(anyFlag))
        else $error("zero answered while a fault was held");

    chk_pending_set: assert property (@(posedge sys_clk) disable iff (rst)
        detected |=> faultPending)
        else $error("pending not raised");

    chk_pending_tracks: assert property (@(posedge sys_clk) disable iff (rst)
        !clrEn && !detected |=> faultPending == anyFlag)
        else $error("pending disagrees with flags");

    chk_drain_zero: assert property (@(posedge sys_clk) disable iff (rst)
        state_q.drain |-> queryAns.valid && queryAns.code == NO_FAULT_CODE)
        else $error("drained query returned a code");

    chk_full_drop: assert property (@(posedge sys_clk) disable iff (rst)
        &flags && !clrEn |=> u_bank.bank_q.code == $past(u_bank.bank_q.code))
        else $error("full bank overwrote a code");

    // Every held pair keeps its flag until a query picks it
    genvar p;
    generate
        for (p = 0; p < NUM_PAIRS; p++) begin : g_hold
            chk_pair_hold: assert property (@(posedge sys_clk) disable iff (rst)
                flags[p] && !(clrEn && hitIdx == IDX_W'(p)) |=> flags[p])
                else $error("held fault flag lost");
            chk_free_zero: assert property (@(posedge sys_clk) disable iff (rst)
                !flags[p] |-> u_bank.bank_q.code[p] == NO_FAULT_CODE)
                else $error("free pair holds a code");
        end
    endgenerate

endmodule : command_error_capture

// File: fault_pair_bank.sv
/*
 Bank of sticky flag/code pairs with registered read-out.
 Assumes at most one capture and one clear per cycle.
*/
`timescale 1ns/1ps
module fault_pair_bank
    import fault_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Capture
    input  wire logic                 capEn,
    input  wire logic [CODE_W-1:0]    capCode,
    // Clear and read
    input  wire logic                 clrEn,
    input  wire logic [IDX_W-1:0]     clrIdx,
    input  wire logic [IDX_W-1:0]     rdIdx,
    output logic      [CODE_W-1:0]    rdCode,
    output logic      [NUM_PAIRS-1:0] flags
);

    typedef struct packed {
        logic [NUM_PAIRS-1:0]             flag;
        logic [NUM_PAIRS-1:0][CODE_W-1:0] code;
        logic [CODE_W-1:0]                rd;
    } bank_t;

    bank_t bank_q;
    bank_t bank_d;
    logic [NUM_PAIRS-1:0] freeMask;
    logic [NUM_PAIRS-1:0] grant;
    logic [IDX_W-1:0]     nextIdx;

    // Capture lands in lowest free pair; a full bank drops the fault
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : g_pick
            if (g == 0) begin : g_first
                assign grant[g] = freeMask[g];
            end else begin : g_rest
                assign grant[g] = freeMask[g] && !(|freeMask[g-1:0]);
            end
        end
    endgenerate

    // Pair being cleared this cycle is not free yet, keeping read and clear ordered
    assign freeMask = ~bank_q.flag;

    always_comb begin
        nextIdx = rdIdx;
        bank_d = bank_q;
        if (clrEn) begin
            bank_d.flag[clrIdx] = 1'b0;
            bank_d.code[clrIdx] = NO_FAULT_CODE;
        end
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (capEn && grant[i]) begin
                bank_d.flag[i] = 1'b1;
                bank_d.code[i] = capCode;
            end
        end
        // Read-out tracks the lowest pair pending after this edge, so a
        // query in the very next cycle never sees a stale code
        for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
            if (bank_d.flag[i]) begin
                nextIdx = IDX_W'(i);
            end
        end
        bank_d.rd = bank_d.code[nextIdx];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bank_q <= '0;
        end else begin
            bank_q <= bank_d;
        end
    end

    assign rdCode = bank_q.rd;
    assign flags  = bank_q.flag;

    chk_held_code_stable: assert property (@(posedge sys_clk) disable iff (rst)
        bank_q.flag[0] && !(clrEn && clrIdx == '0) |=> bank_q.code[0] == $past(bank_q.code[0]))
        else $error("held fault code changed");

endmodule : fault_pair_bank

// File: fault_pkg.sv
/*
 Shared types and constants for the command fault capture unit.
 Assumes a single 32-bit command clock domain.
*/
package fault_pkg;

    localparam int CODE_W    = 32;
    localparam int NUM_PAIRS = 4;
    localparam int IDX_W     = 2;
    localparam int KIND_W    = 3;

    // Fault codes; zero means no fault
    localparam logic [CODE_W-1:0] NO_FAULT_CODE         = 32'h0000_0000;
    localparam logic [CODE_W-1:0] BAD_ENUM_CODE         = 32'h0000_0500;
    localparam logic [CODE_W-1:0] BAD_VALUE_CODE        = 32'h0000_0501;
    localparam logic [CODE_W-1:0] ILLEGAL_OP_CODE       = 32'h0000_0502;
    localparam logic [CODE_W-1:0] STACK_OVER_CODE       = 32'h0000_0503;
    localparam logic [CODE_W-1:0] STACK_UNDER_CODE      = 32'h0000_0504;
    localparam logic [CODE_W-1:0] memory_exhausted_code = 32'h0000_0505;
    localparam logic [CODE_W-1:0] TABLE_LARGE_CODE      = 32'h0000_0506;
    localparam logic [CODE_W-1:0] FB_INCOMPLETE_CODE    = 32'h0000_0506 + 32'h0000_0001;

    // Explicit fault kinds reported by command checkers
    typedef enum logic [KIND_W-1:0] {
        KIND_NONE, KIND_ILLEGAL_OP, KIND_FB_INCOMPLETE, KIND_STACK_OVER,
        KIND_STACK_UNDER, KIND_TABLE_LARGE, KIND_NO_MEMORY
    } fault_kind_t;

    // One command under check
    typedef struct packed {
        logic              valid;
        logic              enumLegal;
        logic              sizeChecked;
        logic [CODE_W-1:0] sizeArg;
        fault_kind_t       explicitKind;
        logic [CODE_W-1:0] result;
        logic              hasResult;
        logic              ptrWrite;
    } cmd_check_t;

    // Verdict handed back to the command pipeline
    typedef struct packed {
        logic              valid;
        logic              commit;
        logic              ptrWrite;
        logic [CODE_W-1:0] result;
        logic              undefined;
    } cmd_verdict_t;

    typedef struct packed {
        logic              valid;
        logic [CODE_W-1:0] code;
    } query_ans_t;

endpackage : fault_pkg

// File: host_model.sv
/*
 Host side of the fault capture unit: issues code queries, returns answers.
 Assumes the answer is registered one cycle after the query edge.
*/
`timescale 1ns/1ps
module host_model
    import fault_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Query port
    output logic            fault_code_query,
    input  wire query_ans_t queryAns
);
    initial fault_code_query = 1'b0;

    // One pulse per query; answer taken once the registering edge has landed
    task automatic query(output logic [CODE_W-1:0] code, output logic got);
        @(posedge sys_clk);
        fault_code_query <= 1'b1;
        @(posedge sys_clk);
        fault_code_query <= 1'b0;
        #1;
        got  = queryAns.valid;
        code = queryAns.code;
    endtask : query
endmodule : host_model

// File: tb.sv
/*
 Self-checking bench for command_error_capture.
 Assumes host_model as the query partner and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
    import fault_pkg::*;
    logic         sys_clk;
    logic         rst;
    cmd_check_t   cmdIn;
    cmd_verdict_t verdictOut;
    logic         faultQuery;
    query_ans_t   queryAns;
    logic         faultPending;
    int           failures;
    int           checks;
    int           cycles;
    localparam logic [CODE_W-1:0] RES = 32'h0000_1234;

    command_error_capture i_command_error_capture (
        .sys_clk(sys_clk), .rst(rst), .cmdIn(cmdIn), .verdictOut(verdictOut),
        .fault_code_query(faultQuery), .queryAns(queryAns), .faultPending(faultPending));
    host_model i_host_model (
        .sys_clk(sys_clk), .fault_code_query(faultQuery), .queryAns(queryAns));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic cmd_check_t mk(logic en, logic sz, logic [CODE_W-1:0] arg,
                                      fault_kind_t k);
        mk = '{1'b1, en, sz, arg, k, RES, 1'b1, 1'b1};
    endfunction : mk

    task automatic qry(input logic [CODE_W-1:0] exp);
        logic [CODE_W-1:0] code;
        logic              got;
        i_host_model.query(code, got);
        chk(32'(got), 32'h1);
        chk(code, exp);
    endtask : qry

    // Discarded commands must show no commit, no pointer write, zero result
    task automatic send(input cmd_check_t c, input logic ok);
        @(posedge sys_clk);
        cmdIn <= c;
        @(posedge sys_clk);
        cmdIn.valid <= 1'b0;
        #1;
        chk(32'(verdictOut.valid), 32'h1);
        chk(32'(verdictOut.commit), 32'(ok));
        chk(32'(verdictOut.ptrWrite), 32'(ok));
        chk(verdictOut.result, ok ? RES : NO_FAULT_CODE);
    endtask : send

    task automatic t_reset();
        chk(32'(faultPending), 32'h0);
        qry(NO_FAULT_CODE);
    endtask : t_reset

    task automatic t_implicit();
        send(mk(1'b1, 1'b1, 32'h0000_0010, KIND_NONE), 1'b1);
        send(mk(1'b1, 1'b0, 32'h8000_0000, KIND_NONE), 1'b1);
        qry(NO_FAULT_CODE);
        send(mk(1'b0, 1'b0, 32'h0, KIND_NONE), 1'b0);
        qry(BAD_ENUM_CODE);
        qry(NO_FAULT_CODE);
        send(mk(1'b1, 1'b1, 32'h8000_0000, KIND_NONE), 1'b0);
        qry(BAD_VALUE_CODE);
        send(mk(1'b0, 1'b1, 32'hFFFF_FFFF, KIND_ILLEGAL_OP), 1'b0);
        qry(BAD_ENUM_CODE);
        qry(NO_FAULT_CODE);
    endtask : t_implicit

    task automatic t_kinds();
        fault_kind_t       k [5] = '{KIND_ILLEGAL_OP, KIND_FB_INCOMPLETE, KIND_STACK_OVER,
                                     KIND_STACK_UNDER, KIND_TABLE_LARGE};
        logic [CODE_W-1:0] c [5] = '{ILLEGAL_OP_CODE, FB_INCOMPLETE_CODE, STACK_OVER_CODE,
                                     STACK_UNDER_CODE, TABLE_LARGE_CODE};
        for (int i = 0; i < 5; i++) begin
            send(mk(1'b1, 1'b0, 32'h0, k[i]), 1'b0);
            qry(c[i]);
        end
    endtask : t_kinds

    // Five faults back to back into four pairs; the last finds the bank full
    task automatic t_burst();
        fault_kind_t k [4] = '{KIND_STACK_OVER, KIND_STACK_UNDER, KIND_TABLE_LARGE,
                               KIND_ILLEGAL_OP};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            cmdIn <= mk(1'b1, 1'b0, 32'h0, k[i]);
        end
        @(posedge sys_clk);
        cmdIn <= mk(1'b0, 1'b0, 32'h0, KIND_NONE);
        @(posedge sys_clk);
        cmdIn.valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(32'(faultPending), 32'h1);
        qry(STACK_OVER_CODE);
        qry(STACK_UNDER_CODE);
        qry(TABLE_LARGE_CODE);
        qry(ILLEGAL_OP_CODE);
        qry(NO_FAULT_CODE);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(32'(faultPending), 32'h0);
    endtask : t_burst

    // Memory fault still commits; undefined stays up until a reset
    task automatic t_memory();
        send(mk(1'b1, 1'b0, 32'h0, KIND_NO_MEMORY), 1'b1);
        chk(32'(verdictOut.undefined), 32'h1);
        qry(memory_exhausted_code);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(32'(verdictOut.undefined), 32'h0);
        qry(NO_FAULT_CODE);
    endtask : t_memory

    initial begin
        failures = 0;
        checks   = 0;
        cycles   = 0;
        rst      = 1'b1;
        cmdIn    = '{1'b0, 1'b1, 1'b0, 32'h0, KIND_NONE, 32'h0, 1'b0, 1'b0};
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_implicit();
        t_kinds();
        t_burst();
        t_memory();
        end_sim();
    end
endmodule : tb
